// [core/sync_burst_sram_access.sv]
`timescale 1ns/1ns
`default_nettype none
module sync_burst_sram_access
    import sram_burst_pkg::*;
#(
    parameter int ADDR_W = ADDR_BITS,
    parameter int DATA_W = DATA_BITS
) (
    // Clock and reset
    input  wire logic                  clock_i,
    input  wire logic                  rst_i,
    // Address and shared data bus with parity
    input  wire logic [ADDR_W-1:0]     addr_i,
    input  wire logic [DATA_W-1:0]     data_i,
    output logic      [DATA_W-1:0]     data_o,
    output logic                       data_oe_o,
    // Selects, strobes and advance
    input  wire logic                  pipelined_select_n_i,
    input  wire logic                  depth_select_hi_i,
    input  wire logic                  depth_select_lo_n_i,
    input  wire logic                  cpu_addr_strobe_n_i,
    input  wire logic                  ctrl_addr_strobe_n_i,
    input  wire logic                  burst_advance_n_i,
    // Write controls
    input  wire logic                  all_bytes_write_n_i,
    input  wire logic                  partial_write_enable_n_i,
    input  wire logic [LANE_COUNT-1:0] byte_lane_select_n_i,
    // Output enable, burst order strap, sleep
    input  wire logic                  output_enable_n_i,
    input  wire logic                  burst_mode_i,
    input  wire logic                  sleep_req_i,
    output logic                       sleeping_o,
    // Boundary scan
    input  wire logic                  scan_clk_i,
    input  wire logic                  scan_di_i,
    input  wire logic                  scan_mode_sel_i,
    output logic                       scan_do_o,
    output logic                       scan_reset_o
);
    // Input registers
    ctl_t              ctl_q, ctl_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic [DATA_W-1:0] wdata_q, wdata_d;

    always_comb begin
        ctl_d.pipelined_select_n     = pipelined_select_n_i;
        ctl_d.depth_select_hi        = depth_select_hi_i;
        ctl_d.depth_select_lo_n      = depth_select_lo_n_i;
        ctl_d.cpu_addr_strobe_n      = cpu_addr_strobe_n_i;
        ctl_d.ctrl_addr_strobe_n     = ctrl_addr_strobe_n_i;
        ctl_d.burst_advance_n        = burst_advance_n_i;
        ctl_d.all_bytes_write_n      = all_bytes_write_n_i;
        ctl_d.partial_write_enable_n = partial_write_enable_n_i;
        ctl_d.byte_lane_select_n     = byte_lane_select_n_i;
        ctl_d.output_enable_n        = output_enable_n_i;
        ctl_d.burst_mode             = burst_mode_i;
        addr_d                       = addr_i;
        wdata_d                      = data_i;
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            ctl_q   <= CTL_IDLE;
            addr_q  <= '0;
            wdata_q <= '0;
        end else begin
            ctl_q   <= ctl_d;
            addr_q  <= addr_d;
            wdata_q <= wdata_d;
        end
    end

    // Sleep request is asynchronous, so it gets a two-stage synchroniser
    logic   sleep_meta_q;
    logic   sleep_sync_q;
    sleep_t sleep_q, sleep_d;
    logic [1:0] sleep_cnt_q, sleep_cnt_d;
    logic   sleeping_q, sleeping_d;
    logic   awake;

    always_comb begin
        sleep_d     = sleep_q;
        sleep_cnt_d = sleep_cnt_q;
        case (sleep_q)
            S_AWAKE: begin
                if (sleep_sync_q) begin
                    sleep_d     = S_ENTER;
                    sleep_cnt_d = 2'h0;
                end
            end
            S_ENTER: begin
                sleep_cnt_d = sleep_cnt_q + 2'h1;
                if (sleep_cnt_q == SLEEP_ENTER_CYCLES - 2'h1) begin
                    sleep_d = S_SLEEP;
                end
            end
            S_SLEEP: begin
                if (!sleep_sync_q) begin
                    sleep_d     = S_EXIT;
                    sleep_cnt_d = 2'h0;
                end
            end
            default: begin
                sleep_cnt_d = sleep_cnt_q + 2'h1;
                if (sleep_cnt_q == SLEEP_EXIT_CYCLES - 2'h1) begin
                    sleep_d = S_AWAKE;
                end
            end
        endcase
        sleeping_d = (sleep_d == S_SLEEP);
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            sleep_meta_q <= 1'b0;
            sleep_sync_q <= 1'b0;
            sleep_q      <= S_AWAKE;
            sleep_cnt_q  <= 2'h0;
            sleeping_q   <= 1'b0;
        end else begin
            sleep_meta_q <= sleep_req_i;
            sleep_sync_q <= sleep_meta_q;
            sleep_q      <= sleep_d;
            sleep_cnt_q  <= sleep_cnt_d;
            sleeping_q   <= sleeping_d;
        end
    end

    assign awake      = (sleep_q == S_AWAKE);
    assign sleeping_o = sleeping_q;

    // Cycle decode on the registered inputs
    logic                  sel;
    logic                  cpu_go;
    logic                  ctrl_go;
    logic                  start;
    logic                  wr_req;
    logic [LANE_COUNT-1:0] lane_en;

    assign sel = !ctl_q.pipelined_select_n && ctl_q.depth_select_hi
              && !ctl_q.depth_select_lo_n;
    assign cpu_go  = !ctl_q.cpu_addr_strobe_n && !ctl_q.pipelined_select_n;
    assign ctrl_go = !ctl_q.ctrl_addr_strobe_n && !cpu_go;
    assign start   = awake && (cpu_go || ctrl_go);
    assign wr_req  = !ctl_q.all_bytes_write_n
                  || (!ctl_q.partial_write_enable_n && !(&ctl_q.byte_lane_select_n));

    always_comb begin
        if (!ctl_q.all_bytes_write_n) begin
            lane_en = '1;
        end else if (!ctl_q.partial_write_enable_n) begin
            lane_en = ~ctl_q.byte_lane_select_n;
        end else begin
            lane_en = '0;
        end
    end

    // Burst state: the base holds the start address, beat counts from it
    logic              active_q, active_d;
    logic [ADDR_W-1:0] base_q, base_d;
    logic [1:0]        beat_q, beat_d;
    logic [1:0]        beat_use;
    logic [ADDR_W-1:0] last_addr_q, last_addr_d;
    logic              oe_q, oe_d;
    logic              mask;
    logic              mem_we;
    logic              mem_re;
    logic [ADDR_W-1:0] mem_addr;

    always_comb begin
        active_d = active_q;
        base_d   = base_q;
        beat_d   = beat_q;
        beat_use = beat_q;
        mem_addr = last_addr_q;
        mem_we   = 1'b0;
        mem_re   = 1'b0;
        mask     = 1'b0;
        if (!awake) begin
            active_d = 1'b0;
        end else if (start) begin
            if (sel) begin
                active_d = 1'b1;
                base_d   = addr_q;
                beat_d   = 2'h0;
                mem_addr = addr_q;
                if (ctrl_go && wr_req) begin
                    mem_we = 1'b1;
                end else begin
                    mem_re = 1'b1;
                    mask   = !active_q;
                end
            end else begin
                active_d = 1'b0;
            end
        end else if (active_q) begin
            if (!ctl_q.burst_advance_n) begin
                beat_use = beat_q + 2'h1;
            end
            beat_d   = beat_use;
            mem_addr = {base_q[ADDR_W-1:2],
                        burst_lsb(base_q[1:0], beat_use, ctl_q.burst_mode)};
            if (wr_req) begin
                mem_we = 1'b1;
            end else begin
                mem_re = 1'b1;
            end
        end
        last_addr_d = mem_addr;
        // Output enable is taken from its input register, one cycle late
        oe_d = mem_re && !ctl_q.output_enable_n && !mask;
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            active_q    <= 1'b0;
            base_q      <= '0;
            beat_q      <= 2'h0;
            last_addr_q <= '0;
            oe_q        <= 1'b0;
        end else begin
            active_q    <= active_d;
            base_q      <= base_d;
            beat_q      <= beat_d;
            last_addr_q <= last_addr_d;
            oe_q        <= oe_d;
        end
    end

    assign data_oe_o = oe_q;

    sram_core_mem #(
        .ADDR_W (ADDR_W),
        .DATA_W (DATA_W),
        .LANES  (LANE_COUNT)
    ) u_mem (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .we_i    (mem_we),
        .be_i    (lane_en),
        .re_i    (mem_re),
        .addr_i  (mem_addr),
        .wdata_i (wdata_q),
        .rdata_o (data_o)
    );

    sram_scan_port u_scan (
        .clock_i         (clock_i),
        .rst_i           (rst_i),
        .scan_clk_i      (scan_clk_i),
        .scan_di_i       (scan_di_i),
        .scan_mode_sel_i (scan_mode_sel_i),
        .scan_do_o       (scan_do_o),
        .scan_reset_o    (scan_reset_o)
    );

    a_write_floats: assert property (@(posedge clock_i) disable iff (rst_i)
        mem_we |=> !data_oe_o)
        else $error("bus driven after a write cycle");

    a_first_masked: assert property (@(posedge clock_i) disable iff (rst_i)
        mask |=> !data_oe_o)
        else $error("bus driven in first read after deselect");

    a_idle_floats: assert property (@(posedge clock_i) disable iff (rst_i)
        (!mem_re || ctl_q.output_enable_n) |=> !data_oe_o)
        else $error("bus driven outside a selected read");

    a_cpu_reads: assert property (@(posedge clock_i) disable iff (rst_i)
        (awake && cpu_go && sel) |-> (mem_re && !mem_we && mem_addr == addr_q))
        else $error("processor strobe start was not a read");

    a_global_all: assert property (@(posedge clock_i) disable iff (rst_i)
        (mem_we && !ctl_q.all_bytes_write_n) |-> (&lane_en))
        else $error("global write missed a lane");

    a_lane_pick: assert property (@(posedge clock_i) disable iff (rst_i)
        (mem_we && ctl_q.all_bytes_write_n)
        |-> (!ctl_q.partial_write_enable_n && lane_en == ~ctl_q.byte_lane_select_n))
        else $error("partial write lanes wrong");

    a_ctrl_write: assert property (@(posedge clock_i) disable iff (rst_i)
        (awake && ctrl_go && sel && wr_req) |-> (mem_we && mem_addr == addr_q))
        else $error("controller strobe write not taken");

    a_cpu_ignored: assert property (@(posedge clock_i) disable iff (rst_i)
        (ctl_q.pipelined_select_n && ctl_q.ctrl_addr_strobe_n && !active_q)
        |-> (!mem_re && !mem_we))
        else $error("access began while deselected");

    a_burst_load: assert property (@(posedge clock_i) disable iff (rst_i)
        (start && sel) |=> (base_q[1:0] == $past(addr_q[1:0]) && beat_q == 2'h0))
        else $error("burst counter not loaded");

    a_hold_addr: assert property (@(posedge clock_i) disable iff (rst_i)
        (awake && !start && active_q && ctl_q.burst_advance_n)
        |-> (mem_addr == last_addr_q))
        else $error("burst address moved without advance");

    a_four_wrap: assert property (@(posedge clock_i) disable iff (rst_i)
        (awake && !start && active_q && !ctl_q.burst_advance_n && beat_q == 2'h3)
        |-> (mem_addr == base_q))
        else $error("burst did not wrap inside four");

    a_linear_next: assert property (@(posedge clock_i) disable iff (rst_i)
        (awake && !start && active_q && !ctl_q.burst_advance_n
         && ctl_q.burst_mode == MODE_LINEAR)
        |-> (mem_addr[1:0] == last_addr_q[1:0] + 2'h1))
        else $error("linear beat out of order");

    a_leave_next: assert property (@(posedge clock_i) disable iff (rst_i)
        (awake && !start && active_q && !ctl_q.burst_advance_n
         && ctl_q.burst_mode != MODE_LINEAR)
        |-> ((mem_addr[1:0] ^ base_q[1:0])
             == (last_addr_q[1:0] ^ base_q[1:0]) + 2'h1))
        else $error("interleaved beat out of order");

    a_sleep_entry: assert property (@(posedge clock_i) disable iff (rst_i)
        (sleep_q == S_AWAKE && sleep_sync_q)
        |=> (sleep_q == S_ENTER && !sleeping_o)[*2] ##1 sleeping_o)
        else $error("sleep entry not two cycles");

    a_sleep_exit: assert property (@(posedge clock_i) disable iff (rst_i)
        (sleep_q == S_SLEEP && !sleep_sync_q)
        |=> (sleep_q == S_EXIT && !sleeping_o)[*2] ##1 awake)
        else $error("sleep exit not two cycles");

    a_sleep_abandon: assert property (@(posedge clock_i) disable iff (rst_i)
        !awake |-> (!mem_we && !mem_re) ##1 !active_q)
        else $error("access went on during sleep");
endmodule
`default_nettype wire

// [core/sram_burst_pkg.sv]
package sram_burst_pkg;

    // Geometry defaults: four byte lanes, each eight data bits plus parity
    localparam int ADDR_BITS  = 19;
    localparam int DATA_BITS  = 36;
    localparam int LANE_COUNT = 4;

    // Burst order strap level that picks the linear sequence
    localparam logic MODE_LINEAR = 1'b0;

    // Sleep entry and sleep_recovery_time, both in clock cycles
    localparam logic [1:0] SLEEP_ENTER_CYCLES = 2'h2;
    localparam logic [1:0] SLEEP_EXIT_CYCLES  = 2'h2;

    // Consecutive scan mode-select highs that force the scan logic idle
    localparam logic [2:0] TAP_RESET_ONES = 3'h5;

    typedef struct packed {
        logic                  pipelined_select_n;
        logic                  depth_select_hi;
        logic                  depth_select_lo_n;
        logic                  cpu_addr_strobe_n;
        logic                  ctrl_addr_strobe_n;
        logic                  burst_advance_n;
        logic                  all_bytes_write_n;
        logic                  partial_write_enable_n;
        logic [LANE_COUNT-1:0] byte_lane_select_n;
        logic                  output_enable_n;
        logic                  burst_mode;
    } ctl_t;

    localparam ctl_t CTL_IDLE = '{
        pipelined_select_n:     1'b1,
        depth_select_hi:        1'b0,
        depth_select_lo_n:      1'b1,
        cpu_addr_strobe_n:      1'b1,
        ctrl_addr_strobe_n:     1'b1,
        burst_advance_n:        1'b1,
        all_bytes_write_n:      1'b1,
        partial_write_enable_n: 1'b1,
        byte_lane_select_n:     '1,
        output_enable_n:        1'b1,
        burst_mode:             1'b1
    };

    typedef enum logic [1:0] {
        S_AWAKE,
        S_ENTER,
        S_SLEEP,
        S_EXIT
    } sleep_t;

    // Low two address bits of a beat, for either burst order
    function automatic logic [1:0] burst_lsb(input logic [1:0] first,
                                             input logic [1:0] beat,
                                             input logic       mode);
        if (mode == MODE_LINEAR) begin
            return first + beat;
        end
        return first ^ beat;
    endfunction

endpackage

// [core/sram_core_mem.sv]
`timescale 1ns/1ns
`default_nettype none
module sram_core_mem #(
    parameter int ADDR_W = 19,
    parameter int DATA_W = 36,
    parameter int LANES  = 4
) (
    // Clock and reset
    input  wire logic              clock_i,
    input  wire logic              rst_i,
    // Access
    input  wire logic              we_i,
    input  wire logic [LANES-1:0]  be_i,
    input  wire logic              re_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] wdata_i,
    output logic      [DATA_W-1:0] rdata_o
);
    localparam int LANE_W = DATA_W / LANES;

    // Contents carry no reset, so sleep and reset never disturb them
    logic [DATA_W-1:0] store_q [2**ADDR_W];
    logic [DATA_W-1:0] rdata_q;

    always_ff @(posedge clock_i) begin
        for (int i = 0; i < LANES; i++) begin
            if (we_i && be_i[i]) begin
                store_q[addr_i][i*LANE_W +: LANE_W] <= wdata_i[i*LANE_W +: LANE_W];
            end
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_q <= '0;
        end else if (re_i) begin
            rdata_q <= store_q[addr_i];
        end
    end

    assign rdata_o = rdata_q;
endmodule
`default_nettype wire

// [core/sram_scan_port.sv]
`timescale 1ns/1ns
`default_nettype none
module sram_scan_port
    import sram_burst_pkg::*;
(
    // Clock and reset
    input  wire logic clock_i,
    input  wire logic rst_i,
    // Scan pins
    input  wire logic scan_clk_i,
    input  wire logic scan_di_i,
    input  wire logic scan_mode_sel_i,
    output logic      scan_do_o,
    output logic      scan_reset_o
);
    logic       tck_q, tck_d;
    logic       bypass_q, bypass_d;
    logic       tdo_q, tdo_d;
    logic [2:0] ones_q, ones_d;
    logic       idle_q, idle_d;
    logic       tck_rise;
    logic       tck_fall;

    // Scan clock is far slower than clock_i, so edges are found by sampling
    assign tck_rise = scan_clk_i && !tck_q;
    assign tck_fall = !scan_clk_i && tck_q;

    always_comb begin
        tck_d    = scan_clk_i;
        bypass_d = bypass_q;
        tdo_d    = tdo_q;
        ones_d   = ones_q;
        idle_d   = idle_q;
        if (tck_rise) begin
            bypass_d = scan_di_i;
            if (!scan_mode_sel_i) begin
                ones_d = 3'h0;
            end else if (ones_q != TAP_RESET_ONES) begin
                ones_d = ones_q + 3'h1;
            end
            idle_d = (ones_d == TAP_RESET_ONES);
        end
        if (tck_fall) begin
            tdo_d = bypass_q;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            tck_q    <= 1'b0;
            bypass_q <= 1'b0;
            tdo_q    <= 1'b0;
            ones_q   <= 3'h0;
            idle_q   <= 1'b1;
        end else begin
            tck_q    <= tck_d;
            bypass_q <= bypass_d;
            tdo_q    <= tdo_d;
            ones_q   <= ones_d;
            idle_q   <= idle_d;
        end
    end

    assign scan_do_o    = tdo_q;
    assign scan_reset_o = idle_q;

    a_do_on_fall: assert property (@(posedge clock_i) disable iff (rst_i)
        $changed(scan_do_o) |-> $past(tck_fall))
        else $error("scan output changed without a scan clock fall");

    a_di_on_rise: assert property (@(posedge clock_i) disable iff (rst_i)
        $changed(bypass_q) |-> $past(tck_rise))
        else $error("scan input taken without a scan clock rise");
endmodule
`default_nettype wire

// [bench/bus_master_model.sv]
`timescale 1ns/1ns
`default_nettype none
module bus_master_model
    import sram_burst_pkg::*;
(
    // Clock
    input  wire logic                 clock_i,
    // Device side and master write data
    input  wire logic [DATA_BITS-1:0] dev_data_i,
    input  wire logic                 dev_oe_i,
    input  wire logic                 drive_i,
    input  wire logic [DATA_BITS-1:0] wdata_i,
    output logic      [DATA_BITS-1:0] bus_o
);
    logic [DATA_BITS-1:0] last_q = '0;

    // A released bus flips each cycle so a stale value never reads as valid
    always_comb begin
        if (dev_oe_i) begin
            bus_o = dev_data_i;
        end else if (drive_i) begin
            bus_o = wdata_i;
        end else begin
            bus_o = ~last_q;
        end
    end

    always_ff @(posedge clock_i) begin
        last_q <= bus_o;
    end
endmodule
`default_nettype wire

// [bench/sync_burst_sram_access_tb.sv]
`timescale 1ns/1ns
`default_nettype none
module sync_burst_sram_access_tb
    import sram_burst_pkg::*;
;
    typedef struct packed {
        logic [7:0]  k;
        logic [5:0]  a;
        logic [35:0] w;
        logic [35:0] e;
        logic        eo;
        logic        ck;
    } row_t;

    logic        clock_i = 1'b0;
    logic        rst_i   = 1'b1;
    logic        mode    = 1'b1;
    ctl_t        ctl     = CTL_IDLE;
    logic [5:0]  addr    = '0;
    logic [35:0] wdata   = '0;
    logic        drive   = 1'b0;
    logic        sleep_req_i = 1'b0;
    logic        scan_clk_i  = 1'b0;
    logic        scan_di_i   = 1'b0;
    logic        scan_ms     = 1'b0;
    logic [35:0] bus, data_o, sd;
    logic        data_oe_o, sleeping_o, scan_do_o, scan_reset_o, so;
    logic [35:0] ex [4];
    row_t        rows [13];
    int          failures = 0;
    int          checked  = 0;

    always #2 clock_i = ~clock_i;

    sync_burst_sram_access #(.ADDR_W(6)) dut_u (
        .clock_i(clock_i), .rst_i(rst_i), .addr_i(addr), .data_i(bus),
        .data_o(data_o), .data_oe_o(data_oe_o),
        .pipelined_select_n_i(ctl.pipelined_select_n),
        .depth_select_hi_i(ctl.depth_select_hi),
        .depth_select_lo_n_i(ctl.depth_select_lo_n),
        .cpu_addr_strobe_n_i(ctl.cpu_addr_strobe_n),
        .ctrl_addr_strobe_n_i(ctl.ctrl_addr_strobe_n),
        .burst_advance_n_i(ctl.burst_advance_n),
        .all_bytes_write_n_i(ctl.all_bytes_write_n),
        .partial_write_enable_n_i(ctl.partial_write_enable_n),
        .byte_lane_select_n_i(ctl.byte_lane_select_n),
        .output_enable_n_i(ctl.output_enable_n), .burst_mode_i(ctl.burst_mode),
        .sleep_req_i(sleep_req_i), .sleeping_o(sleeping_o),
        .scan_clk_i(scan_clk_i), .scan_di_i(scan_di_i), .scan_mode_sel_i(scan_ms),
        .scan_do_o(scan_do_o), .scan_reset_o(scan_reset_o));

    bus_master_model partner_u (.clock_i(clock_i), .dev_data_i(data_o),
        .dev_oe_i(data_oe_o), .drive_i(drive), .wdata_i(wdata), .bus_o(bus));

    function automatic logic [35:0] pat(input logic [5:0] a);
        return {4{3'h5, a}};
    endfunction

    // Codes: W/B/R ctrl starts, P/X cpu starts, C cpu strobe while deselected, A advance, M write, D deselect
    function automatic ctl_t mk(input logic [7:0] k);
        ctl_t c;
        c = CTL_IDLE;
        c.burst_mode = mode;
        if (k inside {"W", "B", "R", "P", "X", "C"}) begin
            c.pipelined_select_n = (k == "C");
            c.depth_select_hi = 1'b1;
            c.depth_select_lo_n = 1'b0;
        end
        c.ctrl_addr_strobe_n = !(k inside {"W", "B", "R", "X", "D"});
        c.cpu_addr_strobe_n = !(k inside {"P", "X", "C"});
        c.all_bytes_write_n = !(k inside {"W", "X", "M"});
        c.partial_write_enable_n = (k != "B");
        // Lane selects without byte write enable must stay a read
        c.byte_lane_select_n = (k inside {"B", "A"}) ? 4'hA : 4'hF;
        c.output_enable_n = !(k inside {"P", "A", "B"});
        c.burst_advance_n = (k != "A");
        return c;
    endfunction

    task automatic chk(input logic [35:0] s, input logic [35:0] e);
        checked++;
        if (s !== e) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic cyc(input logic [7:0] k, input logic [5:0] a, input logic [35:0] w);
        @(negedge clock_i);
        sd = data_o;
        so = data_oe_o;
        ctl = mk(k);
        addr = a;
        wdata = w;
        drive = (k inside {"W", "B", "M"});
    endtask

    task automatic do_reset;
        rst_i = 1'b1;
        ctl = mk("I");
        repeat (8) @(negedge clock_i);
        chk(36'(data_oe_o), 36'h0);
        chk(36'(sleeping_o), 36'h0);
        chk(36'(scan_reset_o), 36'h1);
        rst_i = 1'b0;
    endtask

    task automatic burst(input logic [1:0] s);
        logic [1:0] b;
        cyc("D", 6'h0, '0);
        for (int k = 0; k < 6; k++) begin
            cyc(k == 0 ? "P" : (k < 4 ? "A" : "I"), {4'h0, s}, '0);
            if (k >= 2) begin
                b = mode ? s ^ 2'(k - 2) : s + 2'(k - 2);
                chk(sd, ex[b]);
                chk(36'(so), 36'(k != 2));
            end
        end
    endtask

    task automatic wait_sleep(input logic v, input int e);
        int n;
        n = 0;
        while (sleeping_o !== v && n < 12) begin
            cyc("I", 6'h0, '0);
            n++;
        end
        chk(36'(n), 36'(e));
        if (n >= 12) begin
            give_verdict();
        end
    endtask

    task automatic scan_bit(input logic v, input logic p, input logic m, input logic r);
        scan_di_i = v;
        scan_ms = m;
        repeat (4) @(negedge clock_i);
        scan_clk_i = 1'b1;
        repeat (4) @(negedge clock_i);
        chk(36'(scan_do_o), 36'(p));
        scan_clk_i = 1'b0;
        repeat (4) @(negedge clock_i);
        chk(36'(scan_do_o), 36'(v));
        chk(36'(scan_reset_o), 36'(r));
    endtask

    initial begin
        for (int i = 0; i < 4; i++) begin
            ex[i] = pat(6'(i));
            rows[i] = '{"W", 6'(i), pat(6'(i)), '0, 1'b0, 1'b0};
        end
        rows[4]  = '{"W", 6'h5, pat(6'h5), '0, 1'b0, 1'b0};
        rows[5]  = '{"B", 6'h5, '1, '0, 1'b0, 1'b0};
        rows[6]  = '{"R", 6'h5, '0, {9'h145, 9'h1FF, 9'h145, 9'h1FF}, 1'b0, 1'b1};
        rows[7]  = '{"I", 6'h0, '0, '0, 1'b0, 1'b0};
        rows[8]  = '{"X", 6'h2, '0, pat(6'h2), 1'b0, 1'b1};
        rows[9]  = '{"I", 6'h0, '0, pat(6'h2), 1'b0, 1'b1};
        rows[10] = '{"C", 6'h3, '0, pat(6'h2), 1'b0, 1'b1};
        rows[11] = '{"I", 6'h0, '0, '0, 1'b0, 1'b0};
        rows[12] = '{"I", 6'h0, '0, '0, 1'b0, 1'b0};
        do_reset();
        for (int i = 0; i < 13; i++) begin
            cyc(rows[i].k, rows[i].a, rows[i].w);
            if (i >= 2 && rows[i - 2].ck) begin
                chk(sd, rows[i - 2].e);
            end
            if (i >= 2) begin
                chk(36'(so), 36'(rows[i - 2].eo));
            end
        end
        cyc("D", 6'h0, '0);
        cyc("P", 6'h1, '0);
        cyc("M", 6'h1, 36'h987654321);
        ex[1] = 36'h987654321;
        burst(2'h1);
        cyc("D", 6'h0, '0);
        cyc("I", 6'h0, '0);
        sleep_req_i = 1'b1;
        // Two synchroniser edges, one decode edge, then two entry cycles
        wait_sleep(1'b1, 5);
        sleep_req_i = 1'b0;
        wait_sleep(1'b0, 3);
        repeat (3) cyc("I", 6'h0, '0);
        burst(2'h1);
        mode = 1'b0;
        do_reset();
        burst(2'h2);
        scan_bit(1'b1, 1'b0, 1'b0, 1'b0);
        for (int i = 0; i < 5; i++) begin
            scan_bit(i[0], !i[0], 1'b1, i == 4);
        end
        give_verdict();
    end
endmodule
`default_nettype wire
